// *** common/isr_pkg.sv ***
// Constants, field layouts and carrier types for the slave register block.
// Behaviour
// - Control bit 7 is read/write master interrupt enable, reset 0.
// - Control bit 6 enables the slave transmit-done interrupt, reset 0.
// - Control bit 5 enables the second-byte receive interrupt, reset 0.
// - Control bit 4 enables the first-byte receive interrupt, reset 0.
// - Transmit-done flag bit 2 resets to 1, set by hardware, cleared by writing 0.
// - Second-byte flag resets 0, set on second-byte reception, cleared by writing 0.
// - First-byte flag bit 0 resets 0, set on first-byte reception, cleared by writing 0.
// - Register EBh reads back the first received byte; it cannot be written.
// - Register ECh reads the second received byte; a write loads the next transmit byte.
// - Address register bits 7 to 1 give own address, bit 0 enables the slave.
package isr_pkg;

  // Register addresses on the special-function-register bus.
  localparam logic [7:0] ISR_ADR_SLAVE_ADDR = 8'hE9;
  localparam logic [7:0] ISR_ADR_CTRL       = 8'hEA;
  localparam logic [7:0] ISR_ADR_RX_FIRST   = 8'hEB;
  localparam logic [7:0] ISR_ADR_TXRX_SEC   = 8'hEC;

  // Field positions in the control and status register.
  localparam int ISR_BIT_MASTER_IE  = 7;
  localparam int ISR_BIT_TX_DONE_IE = 6;
  localparam int ISR_BIT_RX_SEC_IE  = 5;
  localparam int ISR_BIT_RX_FIR_IE  = 4;
  localparam int ISR_BIT_TX_DONE_F  = 2;
  localparam int ISR_BIT_RX_SEC_F   = 1;
  localparam int ISR_BIT_RX_FIR_F   = 0;

  // Field positions in the slave address register.
  localparam int ISR_BIT_SLAVE_EN = 0;
  localparam int ISR_ADDR_LSB     = 1;

  // Reset values.
  localparam logic [6:0] ISR_RST_OWN_ADDR  = 7'h64;
  localparam logic       ISR_RST_SLAVE_EN  = 1'b0;
  localparam logic [3:0] ISR_RST_ENABLES   = 4'h0;
  localparam logic       ISR_RST_TX_DONE_F = 1'b1;
  localparam logic       ISR_RST_RX_F      = 1'b0;
  localparam logic [7:0] ISR_RST_BYTE      = 8'h00;

  // Receive buffer shape and synchroniser depth.
  localparam int ISR_FIFO_DEPTH = 8;
  localparam int ISR_FIFO_WIDTH = 9;
  localparam int ISR_SYNC_LEN   = 3;

  // One received byte with the holding register it is meant for.
  typedef struct packed {
    logic       second;
    logic [7:0] data;
  } isr_rx_word_t;

  // Settings that the link side copies from the register side.
  typedef struct packed {
    logic [6:0] own_addr;
    logic       slave_en;
    logic [7:0] tx_byte;
  } isr_link_cfg_t;

endpackage

// *** rtl/isr_fifo.sv ***
// Small first-in first-out buffer with valid and ready on both sides.
module isr_fifo
  import isr_pkg::*;
#(
  parameter int WIDTH = ISR_FIFO_WIDTH,
  parameter int DEPTH = ISR_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Handshakes; a full buffer refuses, which stalls the crossing upstream.
  assign in_ready  = (count_r != FULL_CNT);
  assign out_valid = (count_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  // Storage is written only; no reset is needed on the array.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_r  <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule

// *** rtl/isr_slave_regs.sv ***
// Slave interrupt control, receive holding and transmit registers with link crossing.
module isr_slave_regs
  import isr_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       MASTER_IRQ_FLAG,
  output logic            MASTER_IRQ,
  output logic            SLAVE_IRQ,
  input  wire logic       LCLK,
  input  wire logic       L_RX_VALID,
  input  wire logic       L_RX_SECOND,
  input  wire logic [7:0] L_RX_DATA,
  output logic            L_RX_READY,
  input  wire logic       L_TX_DONE,
  output logic      [7:0] L_TX_DATA,
  output logic      [6:0] L_OWN_ADDR,
  output logic            L_SLAVE_EN
);

  // Address match used by both the write and the read decode.
  function automatic logic isr_hit(input logic [7:0] addr, input logic [7:0] target);
    isr_hit = (addr == target);
  endfunction

  // ------------------------------------------------------------------
  // Register side, CLK domain.
  // ------------------------------------------------------------------
  // Software-visible state, plus the toggle that announces a settings change.
  logic [6:0]   own_addr_r;
  logic         slave_en_r;
  logic         master_ie_r;
  logic         tx_done_ie_r;
  logic         rx_sec_ie_r;
  logic         rx_fir_ie_r;
  logic         tx_done_f_r;
  logic         rx_sec_f_r;
  logic         rx_fir_f_r;
  logic [7:0]   rx_first_r;
  logic [7:0]   rx_second_r;
  logic [7:0]   tx_byte_r;
  logic [7:0]   rdata_r;
  logic         cfg_tog_r;

  // Address decode and read path, all combinational.
  logic         wr_addr;
  logic         wr_ctrl;
  logic         wr_txrx;
  logic         rd_addr;
  logic         rd_ctrl;
  logic         rd_rx1;
  logic         rd_rx2;
  logic [7:0]   ctrl_view;
  logic [7:0]   rdata_nxt;

  // Write and read strobes; a write to the first receive byte hits nothing.
  assign wr_addr = SFR_WR & isr_hit(SFR_ADDR, ISR_ADR_SLAVE_ADDR);
  assign wr_ctrl = SFR_WR & isr_hit(SFR_ADDR, ISR_ADR_CTRL);
  assign wr_txrx = SFR_WR & isr_hit(SFR_ADDR, ISR_ADR_TXRX_SEC);
  assign rd_addr = isr_hit(SFR_ADDR, ISR_ADR_SLAVE_ADDR);
  assign rd_ctrl = isr_hit(SFR_ADDR, ISR_ADR_CTRL);
  assign rd_rx1  = isr_hit(SFR_ADDR, ISR_ADR_RX_FIRST);
  assign rd_rx2  = isr_hit(SFR_ADDR, ISR_ADR_TXRX_SEC);

  // Control and status view; bit 3 is reserved and reads as zero.
  assign ctrl_view = {master_ie_r, tx_done_ie_r, rx_sec_ie_r, rx_fir_ie_r,
                      1'b0, tx_done_f_r, rx_sec_f_r, rx_fir_f_r};

  // Read multiplexer; unmapped addresses answer zero.
  // Reads have no side effects on the flags, so software may poll freely.
  assign rdata_nxt = rd_ctrl ? ctrl_view :
                     rd_rx1  ? rx_first_r :
                     rd_rx2  ? rx_second_r :
                     rd_addr ? {own_addr_r, slave_en_r} :
                               8'h00;

  // Read data is registered and appears one cycle after the read strobe.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r <= ISR_RST_BYTE;
    end else if (SFR_RD) begin
      rdata_r <= rdata_nxt;
    end
  end
  assign SFR_RDATA = rdata_r;

  // Slave address register; a write also tells the link side to re-copy.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      own_addr_r <= ISR_RST_OWN_ADDR;
      slave_en_r <= ISR_RST_SLAVE_EN;
    end else if (wr_addr) begin
      own_addr_r <= SFR_WDATA[7:ISR_ADDR_LSB];
      slave_en_r <= SFR_WDATA[ISR_BIT_SLAVE_EN];
    end
  end

  // Transmit byte shares its address with the second receive byte.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_byte_r <= ISR_RST_BYTE;
    end else if (wr_txrx) begin
      tx_byte_r <= SFR_WDATA;
    end
  end

  // Toggle marks a settings change for the link side.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_tog_r <= 1'b0;
    end else if (wr_addr | wr_txrx) begin
      cfg_tog_r <= ~cfg_tog_r;
    end
  end

  // Interrupt enables; plain read/write bits.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      {master_ie_r, tx_done_ie_r, rx_sec_ie_r, rx_fir_ie_r} <= ISR_RST_ENABLES;
    end else if (wr_ctrl) begin
      master_ie_r  <= SFR_WDATA[ISR_BIT_MASTER_IE];
      tx_done_ie_r <= SFR_WDATA[ISR_BIT_TX_DONE_IE];
      rx_sec_ie_r  <= SFR_WDATA[ISR_BIT_RX_SEC_IE];
      rx_fir_ie_r  <= SFR_WDATA[ISR_BIT_RX_FIR_IE];
    end
  end

  // ------------------------------------------------------------------
  // Receive path: link capture, handshake crossing, buffer, holding regs.
  // ------------------------------------------------------------------
  // Link-domain capture stage and its acknowledge synchroniser.
  isr_rx_word_t lrx_word_r;
  logic         lrx_req_r;
  logic [ISR_SYNC_LEN-1:0] lack_sync_r;
  logic         lack_seen_r;

  // Register-domain request synchroniser, buffer handshakes and load strobes.
  logic [ISR_SYNC_LEN-1:0] req_sync_r;
  logic         req_seen_r;
  logic         ack_r;
  logic         xfer_pending;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  isr_rx_word_t fifo_out_word;
  logic         load_first;
  logic         load_second;

  // Link side accepts a byte only when the previous one was acknowledged.
  assign L_RX_READY = (lrx_req_r == lack_seen_r);

  // Capture the byte and flip the request; the word holds until acknowledged.
  // A byte offered while ready is low is simply left on the pins.
  always_ff @(posedge LCLK or negedge RESETN) begin
    if (!RESETN) begin
      lrx_word_r <= '0;
      lrx_req_r  <= 1'b0;
    end else if (L_RX_VALID & L_RX_READY) begin
      lrx_word_r <= '{second: L_RX_SECOND, data: L_RX_DATA};
      lrx_req_r  <= ~lrx_req_r;
    end
  end

  // Acknowledge toggle into the link domain; counted once stages two and three agree.
  always_ff @(posedge LCLK or negedge RESETN) begin
    if (!RESETN) begin
      lack_sync_r <= '0;
      lack_seen_r <= 1'b0;
    end else begin
      lack_sync_r <= {lack_sync_r[ISR_SYNC_LEN-2:0], ack_r};
      if (lack_sync_r[1] == lack_sync_r[2]) begin
        lack_seen_r <= lack_sync_r[2];
      end
    end
  end

  // Request toggle into the register domain, filtered the same way.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_sync_r <= '0;
      req_seen_r <= 1'b0;
    end else begin
      req_sync_r <= {req_sync_r[ISR_SYNC_LEN-2:0], lrx_req_r};
      if (req_sync_r[1] == req_sync_r[2]) begin
        req_seen_r <= req_sync_r[2];
      end
    end
  end

  // A word is pending until the buffer takes it; a full buffer withholds the ack.
  assign xfer_pending = (req_seen_r != ack_r);

  // Acknowledge echoes the request once the buffer has room for the word.
  // Holding the ack back is the only back-pressure that the link side sees.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_r <= 1'b0;
    end else if (xfer_pending & fifo_in_ready) begin
      ack_r <= req_seen_r;
    end
  end

  // The buffer lets the bus side run ahead while software is slow to read.
  isr_fifo #(
    .WIDTH (ISR_FIFO_WIDTH),
    .DEPTH (ISR_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (CLK),
    .rst_n     (RESETN),
    .in_valid  (xfer_pending),
    .in_ready  (fifo_in_ready),
    .in_data   (lrx_word_r),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_word)
  );

  // A holding register is refilled only once software cleared its flag, so no byte is overwritten unread.
  // Limitation: a blocked head word also holds back any later byte for the other register.
  assign fifo_out_ready = fifo_out_word.second ? ~rx_sec_f_r : ~rx_fir_f_r;
  assign load_first     = fifo_out_valid & fifo_out_ready & ~fifo_out_word.second;
  assign load_second    = fifo_out_valid & fifo_out_ready & fifo_out_word.second;

  // Receive holding registers.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_first_r  <= ISR_RST_BYTE;
      rx_second_r <= ISR_RST_BYTE;
    end else begin
      if (load_first) begin
        rx_first_r <= fifo_out_word.data;
      end
      if (load_second) begin
        rx_second_r <= fifo_out_word.data;
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit-done event crossing.
  // ------------------------------------------------------------------
  // Link-domain toggle, its register-domain synchroniser and the edge detector.
  logic                    ltxd_tog_r;
  logic [ISR_SYNC_LEN-1:0] txd_sync_r;
  logic                    txd_seen_r;
  logic                    txd_prev_r;
  logic                    tx_done_evt;

  // A one-cycle pulse on the link clock becomes a toggle that survives the crossing.
  always_ff @(posedge LCLK or negedge RESETN) begin
    if (!RESETN) begin
      ltxd_tog_r <= 1'b0;
    end else if (L_TX_DONE) begin
      ltxd_tog_r <= ~ltxd_tog_r;
    end
  end

  // Toggle into the register domain; stages two and three must agree before it counts.
  // The delayed copy turns each settled toggle into one single-cycle event.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      txd_sync_r <= '0;
      txd_seen_r <= 1'b0;
      txd_prev_r <= 1'b0;
    end else begin
      txd_sync_r <= {txd_sync_r[ISR_SYNC_LEN-2:0], ltxd_tog_r};
      if (txd_sync_r[1] == txd_sync_r[2]) begin
        txd_seen_r <= txd_sync_r[2];
      end
      txd_prev_r <= txd_seen_r;
    end
  end
  // One event per settled toggle; two pulses inside one crossing cancel each other.
  assign tx_done_evt = (txd_seen_r != txd_prev_r);

  // ------------------------------------------------------------------
  // Completion flags; a hardware set in the same cycle as a clear wins.
  // ------------------------------------------------------------------
  // Software clear strobes, one for each flag.
  logic clr_tx_done;
  logic clr_rx_sec;
  logic clr_rx_fir;

  // Writing 0 clears a flag, writing 1 leaves it alone.
  assign clr_tx_done = wr_ctrl & ~SFR_WDATA[ISR_BIT_TX_DONE_F];
  assign clr_rx_sec  = wr_ctrl & ~SFR_WDATA[ISR_BIT_RX_SEC_F];
  assign clr_rx_fir  = wr_ctrl & ~SFR_WDATA[ISR_BIT_RX_FIR_F];

  // A hardware set beats a software clear in the same cycle, so no event is lost.
  // The transmit-done flag starts set, so its enable is best written after a clear.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_done_f_r <= ISR_RST_TX_DONE_F;
      rx_sec_f_r  <= ISR_RST_RX_F;
      rx_fir_f_r  <= ISR_RST_RX_F;
    end else begin
      tx_done_f_r <= tx_done_evt | (tx_done_f_r & ~clr_tx_done);
      rx_sec_f_r  <= load_second | (rx_sec_f_r & ~clr_rx_sec);
      rx_fir_f_r  <= load_first | (rx_fir_f_r & ~clr_rx_fir);
    end
  end

  // Interrupt requests are levels; they drop when the flag or its enable is cleared.
  assign SLAVE_IRQ  = (tx_done_f_r & tx_done_ie_r) |
                      (rx_sec_f_r & rx_sec_ie_r) |
                      (rx_fir_f_r & rx_fir_ie_r);
  assign MASTER_IRQ = MASTER_IRQ_FLAG & master_ie_r;

  // ------------------------------------------------------------------
  // Settings copied to the link domain.
  // ------------------------------------------------------------------
  // Link-domain copy of the settings and the synchroniser of its toggle.
  logic [ISR_SYNC_LEN-1:0] cfg_sync_r;
  logic                    cfg_seen_r;
  isr_link_cfg_t           lcfg_r;
  isr_link_cfg_t           cfg_src;
  logic                    cfg_change;

  // The source words change only together with the toggle, so they are steady when copied.
  assign cfg_src    = '{own_addr: own_addr_r, slave_en: slave_en_r, tx_byte: tx_byte_r};
  assign cfg_change = (cfg_sync_r[1] == cfg_sync_r[2]) & (cfg_sync_r[2] != cfg_seen_r);

  // The settings words are copied only after their toggle settled, so they are quiet when sampled.
  // Limitation: two writes closer than about four link clocks may deliver only the last one.
  always_ff @(posedge LCLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_sync_r <= '0;
      cfg_seen_r <= 1'b0;
      lcfg_r     <= '{own_addr: ISR_RST_OWN_ADDR, slave_en: ISR_RST_SLAVE_EN, tx_byte: ISR_RST_BYTE};
    end else begin
      cfg_sync_r <= {cfg_sync_r[ISR_SYNC_LEN-2:0], cfg_tog_r};
      if (cfg_change) begin
        cfg_seen_r <= cfg_sync_r[2];
        lcfg_r     <= cfg_src;
      end
    end
  end

  // Link-side outputs come straight from link-domain flip-flops.
  assign L_OWN_ADDR = lcfg_r.own_addr;
  assign L_SLAVE_EN = lcfg_r.slave_en;
  assign L_TX_DATA  = lcfg_r.tx_byte;

endmodule

// *** tb/isr_slave_regs_sva.sv ***
// Port-level checker for the slave register block.
module isr_slave_regs_sva
  import isr_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       MASTER_IRQ_FLAG,
  input wire logic       MASTER_IRQ,
  input wire logic       SLAVE_IRQ,
  input wire logic       LCLK,
  input wire logic       L_RX_VALID,
  input wire logic       L_RX_READY,
  input wire logic [7:0] L_TX_DATA,
  input wire logic [6:0] L_OWN_ADDR,
  input wire logic       L_SLAVE_EN
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] en_r;
  logic [7:0] adr_r;
  logic [7:0] tx_r;
  logic       wr_ctl;
  logic       wr_adr;
  logic       wr_tx;

  // Decode of the writes that the shadows follow.
  assign wr_ctl = SFR_WR && (SFR_ADDR == ISR_ADR_CTRL);
  assign wr_adr = SFR_WR && (SFR_ADDR == ISR_ADR_SLAVE_ADDR);
  assign wr_tx  = SFR_WR && (SFR_ADDR == ISR_ADR_TXRX_SEC);

  // Shadows of what software wrote, kept apart from the design's own state.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      en_r  <= ISR_RST_ENABLES;
      adr_r <= {ISR_RST_OWN_ADDR, ISR_RST_SLAVE_EN};
      tx_r  <= ISR_RST_BYTE;
    end else begin
      en_r  <= wr_ctl ? SFR_WDATA[7:4] : en_r;
      adr_r <= wr_adr ? SFR_WDATA : adr_r;
      tx_r  <= wr_tx ? SFR_WDATA : tx_r;
    end
  end

  master_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
    MASTER_IRQ == (MASTER_IRQ_FLAG && en_r[3])) else $error("master request differs from flag and enable");
  enable_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
    SFR_RD && !SFR_WR && SFR_ADDR == ISR_ADR_CTRL |=> SFR_RDATA[7:3] == {en_r, 1'b0})
    else $error("control readback differs from enables written");
  slave_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
    SLAVE_IRQ |-> (|en_r[2:0])) else $error("slave request with no source enabled");
  rdata_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !$past(SFR_RD) |-> $stable(SFR_RDATA)) else $error("read data moved without a read");
  unmapped_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
    SFR_RD && (SFR_ADDR < ISR_ADR_SLAVE_ADDR || SFR_ADDR > ISR_ADR_TXRX_SEC) |=> SFR_RDATA == 8'h00)
    else $error("unmapped read returned data");
  rx_take_a: assert property (@(posedge LCLK) disable iff (!RESETN)
    L_RX_VALID && L_RX_READY |=> !L_RX_READY) else $error("ready stayed high after a byte was taken");
  own_addr_copy_a: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_adr |=> ##[1:8] {L_OWN_ADDR, L_SLAVE_EN} == adr_r) else $error("address copy not updated");
  tx_copy_a: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_tx |=> ##[1:8] L_TX_DATA == tx_r) else $error("transmit byte copy not updated");
endmodule

bind isr_slave_regs isr_slave_regs_sva u_isr_slave_regs_sva (
  .CLK(CLK), .RESETN(RESETN), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
  .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .MASTER_IRQ_FLAG(MASTER_IRQ_FLAG),
  .MASTER_IRQ(MASTER_IRQ), .SLAVE_IRQ(SLAVE_IRQ), .LCLK(LCLK), .L_RX_VALID(L_RX_VALID),
  .L_RX_READY(L_RX_READY), .L_TX_DATA(L_TX_DATA), .L_OWN_ADDR(L_OWN_ADDR), .L_SLAVE_EN(L_SLAVE_EN)
);

// *** tb/isr_link_model.sv ***
// Far-side model that offers received bytes and reports finished transmissions.
module isr_link_model (
  input  wire logic       lclk,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic            rx_second,
  output logic      [7:0] rx_data,
  output logic            tx_done
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle lines at time zero; the data is junk until the first offer.
  initial begin
    rx_valid  = 1'b0;
    rx_second = 1'b0;
    rx_data   = 8'h00;
    tx_done   = 1'b0;
  end

  // Offer one byte from a falling edge and hold it through the rising edge that sees ready.
  task automatic send_byte(input logic sec, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge lclk);
    rx_valid  = 1'b1;
    rx_second = sec;
    rx_data   = d;
    while (!rx_ready && n < 4000) begin
      @(negedge lclk);
      n++;
    end
    @(negedge lclk);
    rx_valid  = 1'b0;
    rx_second = ~sec;
    rx_data   = ~d;
  endtask

  // One link-clock pulse; callers keep pulses well apart so none is lost.
  task automatic tx_pulse();
    @(negedge lclk);
    tx_done = 1'b1;
    @(negedge lclk);
    tx_done = 1'b0;
  endtask
endmodule

// *** tb/isr_slave_regs_tb_top.sv ***
// Self-checking bench for the slave register block and its link crossing.
module isr_slave_regs_tb_top
  import isr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TIMEOUT_CYC = 5000;
  logic       CLK = 1'b0;
  logic       LCLK;
  logic       RESETN;
  logic [7:0] SFR_ADDR;
  logic       SFR_WR;
  logic       SFR_RD;
  logic [7:0] SFR_WDATA;
  logic [7:0] SFR_RDATA;
  logic       MASTER_IRQ_FLAG;
  logic       MASTER_IRQ;
  logic       SLAVE_IRQ;
  logic       L_RX_VALID;
  logic       L_RX_SECOND;
  logic [7:0] L_RX_DATA;
  logic       L_RX_READY;
  logic       L_TX_DONE;
  logic [7:0] L_TX_DATA;
  logic [6:0] L_OWN_ADDR;
  logic       L_SLAVE_EN;
  int         err_count = 0;
  int         comparisons = 0;
  int         cyc_count = 0;

  isr_slave_regs u_isr_slave_regs (
    .CLK(CLK), .RESETN(RESETN), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .MASTER_IRQ_FLAG(MASTER_IRQ_FLAG),
    .MASTER_IRQ(MASTER_IRQ), .SLAVE_IRQ(SLAVE_IRQ), .LCLK(LCLK), .L_RX_VALID(L_RX_VALID),
    .L_RX_SECOND(L_RX_SECOND), .L_RX_DATA(L_RX_DATA), .L_RX_READY(L_RX_READY), .L_TX_DONE(L_TX_DONE),
    .L_TX_DATA(L_TX_DATA), .L_OWN_ADDR(L_OWN_ADDR), .L_SLAVE_EN(L_SLAVE_EN)
  );

  isr_link_model u_isr_link_model (
    .lclk(LCLK), .rx_ready(L_RX_READY), .rx_valid(L_RX_VALID), .rx_second(L_RX_SECOND),
    .rx_data(L_RX_DATA), .tx_done(L_TX_DONE)
  );

  // Register clock, and a link clock with an unrelated phase.
  always #50 CLK = ~CLK;
  initial begin
    LCLK = 1'b0;
    #7;
    forever #16 LCLK = ~LCLK;
  end

  // Cuts a hang short and reports it as a failure.
  always @(posedge CLK) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == TIMEOUT_CYC) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    SFR_ADDR  = a;
    SFR_WDATA = d;
    SFR_WR    = 1'b1;
    @(negedge CLK);
    SFR_WR    = 1'b0;
  endtask

  // Read data lands on the edge after the strobe and is checked once settled.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge CLK);
    SFR_ADDR = a;
    SFR_RD   = 1'b1;
    @(negedge CLK);
    SFR_RD   = 1'b0;
    chk(SFR_RDATA, exp);
  endtask

  // Main sequence; flag bits are written as 1 wherever they must be kept.
  initial begin
    RESETN          = 1'b0;
    SFR_ADDR        = 8'h00;
    SFR_WR          = 1'b0;
    SFR_RD          = 1'b0;
    SFR_WDATA       = 8'h00;
    MASTER_IRQ_FLAG = 1'b0;
    idle(12);
    RESETN = 1'b1;
    chk({1'b0, L_OWN_ADDR}, 8'h64);
    chk({7'h0, L_SLAVE_EN}, 8'h00);
    rd(ISR_ADR_CTRL, 8'h04);
    rd(ISR_ADR_SLAVE_ADDR, 8'hC8);
    MASTER_IRQ_FLAG = 1'b1;
    for (int b = 4; b < 8; b++) begin
      wr(ISR_ADR_CTRL, 8'h04 | (8'h01 << b));
      rd(ISR_ADR_CTRL, 8'h04 | (8'h01 << b));
      chk({7'h0, MASTER_IRQ}, {7'h0, b == 7});
      chk({7'h0, SLAVE_IRQ}, {7'h0, b == 6});
    end
    wr(ISR_ADR_CTRL, 8'h40);
    rd(ISR_ADR_CTRL, 8'h40);
    chk({7'h0, SLAVE_IRQ}, 8'h00);
    u_isr_link_model.tx_pulse();
    idle(12);
    rd(ISR_ADR_CTRL, 8'h44);
    chk({7'h0, SLAVE_IRQ}, 8'h01);
    wr(ISR_ADR_CTRL, 8'h34);
    rd(ISR_ADR_CTRL, 8'h34);
    chk({7'h0, SLAVE_IRQ}, 8'h00);
    u_isr_link_model.send_byte(1'b0, 8'hA5);
    idle(12);
    rd(ISR_ADR_RX_FIRST, 8'hA5);
    rd(ISR_ADR_CTRL, 8'h35);
    chk({7'h0, SLAVE_IRQ}, 8'h01);
    wr(ISR_ADR_RX_FIRST, 8'h3C);
    rd(ISR_ADR_RX_FIRST, 8'hA5);
    // The second byte queues behind the first, which waits on the set flag.
    u_isr_link_model.send_byte(1'b0, 8'h5A);
    u_isr_link_model.send_byte(1'b1, 8'hC3);
    idle(12);
    rd(ISR_ADR_TXRX_SEC, 8'h00);
    wr(ISR_ADR_CTRL, 8'h34);
    idle(12);
    rd(ISR_ADR_RX_FIRST, 8'h5A);
    rd(ISR_ADR_TXRX_SEC, 8'hC3);
    rd(ISR_ADR_CTRL, 8'h37);
    wr(ISR_ADR_TXRX_SEC, 8'h96);
    idle(8);
    chk(L_TX_DATA, 8'h96);
    rd(ISR_ADR_TXRX_SEC, 8'hC3);
    wr(ISR_ADR_SLAVE_ADDR, 8'hA7);
    idle(8);
    rd(ISR_ADR_SLAVE_ADDR, 8'hA7);
    chk({1'b0, L_OWN_ADDR}, 8'h53);
    chk({7'h0, L_SLAVE_EN}, 8'h01);
    rd(8'hE8, 8'h00);
    wr(8'hED, 8'hFF);
    rd(8'hED, 8'h00);
    // Fill the buffer while the first holding register is blocked, then drain it in order.
    for (int i = 0; i < ISR_FIFO_DEPTH; i++) begin
      u_isr_link_model.send_byte(1'b0, 8'h10 + 8'(i));
    end
    for (int i = 0; i < ISR_FIFO_DEPTH; i++) begin
      wr(ISR_ADR_CTRL, 8'h36);
      idle(12);
      rd(ISR_ADR_RX_FIRST, 8'h10 + 8'(i));
    end
    rd(ISR_ADR_CTRL, 8'h37);
    print_verdict();
  end
endmodule
